// *** hdl/sevr_pkg.sv ***
package sevr_pkg;

	localparam int SEVR_WIDTH = 16;
	localparam int SEVR_DEC_DIGITS = 5;

	// bit positions within each event register
	localparam int SEVR_MEAS_OVERFLOW_POS = 3;
	localparam int SEVR_MEAS_TIMEOUT_POS = 4;
	localparam int SEVR_MEAS_READY_POS = 5;
	localparam int SEVR_MEAS_AVERAGE_POS = 9;
	localparam int SEVR_QUES_CAL_POS = 8;
	localparam int SEVR_OPER_LIMIT_POS = 3;
	localparam int SEVR_OPER_TRIP_POS = 4;
	localparam int SEVR_OPER_THERMAL_POS = 5;
	localparam int SEVR_OPER_SUPPLY_POS = 6;

	localparam logic [15:0] SEVR_MEAS_MASK = 16'h0238;
	localparam logic [15:0] SEVR_QUES_MASK = 16'h0100;
	localparam logic [15:0] SEVR_OPER_MASK = 16'h0078;
	localparam logic [15:0] SEVR_RESET_VALUE = 16'h0000;

	typedef enum logic [1:0] {
		SEVR_SEL_MEAS,
		SEVR_SEL_QUES,
		SEVR_SEL_OPER,
		SEVR_SEL_NONE
	} sevr_sel_t;

	// internal conditions, one-cycle event pulses except where noted
	typedef struct packed {
		logic reading_overflow;
		logic pulse_timeout;
		logic reading_ready;
		logic average_done;
		logic cal_invalid;
		logic cal_done_ok;
		logic in_limit;       // level
		logic limit_tripped;
		logic thermal_off;
		logic supply_off;
		logic output_on;
	} sevr_cond_t;

	// answer: 5 bcd digits, most significant first
	typedef struct packed {
		logic [SEVR_DEC_DIGITS*4-1:0] digits;
		logic [SEVR_WIDTH-1:0] raw;
	} sevr_answer_t;

endpackage

// *** hdl/sevr_status_event_registers.sv ***
// Operation
// - a read clears the register after its value is returned, except bits set again in the read cycle
// - value is returned as unsigned integer, one bit per set position
// - measurement bit 3 sets on reading over range
// - measurement bit 4 sets on pulse timeout
// - measurement bit 5 sets when a reading is processed
// - measurement bit 9 sets when average count collected
// - questionable bit 8 sets on invalid calibration constant at power-up
// - calibration fault clears after successful calibration
// - operation bit 3 held set while in current limit
// - operation bit 3 clears when current limit is left
// - operation bit 4 sets when output tripped by current limit
// - operation bit 4 clears when output switched back on
// - operation bit 5 sets on overheat shutdown
// - operation bit 5 clears when output switched back on
// - operation bit 6 sets on supply or overheat shutdown
`timescale 1ns/1ns
`default_nettype none
module sevr_status_event_registers
	import sevr_pkg::*;
(
	input wire logic mclk, // 250 MHz clock
	input wire logic rstn, // async reset, active low
	input wire logic ce, // clock enable, freezes event registers and answer when low
	input wire sevr_cond_t cond, // internal event conditions
	input wire logic query_valid, // read request strobe
	input wire sevr_sel_t query_sel, // register to read
	output logic query_ready, // always high; a request is taken only while ce is high and query_sel is not SEVR_SEL_NONE
	output logic answer_valid, // one-cycle answer strobe
	output sevr_answer_t answer, // registered answer value
	output logic [SEVR_WIDTH-1:0] meas_now, // live measurement register
	output logic [SEVR_WIDTH-1:0] ques_now, // live questionable register
	output logic [SEVR_WIDTH-1:0] oper_now // live operation register
);

	// binary to packed bcd, double dabble
	function automatic logic [SEVR_DEC_DIGITS*4-1:0] to_decimal(input logic [SEVR_WIDTH-1:0] v);
		logic [SEVR_DEC_DIGITS*4+SEVR_WIDTH-1:0] s;
		s = {{(SEVR_DEC_DIGITS*4){1'b0}}, v};
		for (int i = 0; i < SEVR_WIDTH; i++) begin
			for (int d = 0; d < SEVR_DEC_DIGITS; d++) begin
				if (s[SEVR_WIDTH+d*4 +: 4] > 4'h4) begin
					s[SEVR_WIDTH+d*4 +: 4] = s[SEVR_WIDTH+d*4 +: 4] + 4'h3;
				end
			end
			s = s << 1;
		end
		return s[SEVR_DEC_DIGITS*4+SEVR_WIDTH-1 -: SEVR_DEC_DIGITS*4];
	endfunction

	// read-clear with set priority over the clear
	function automatic logic [SEVR_WIDTH-1:0] update(input logic [SEVR_WIDTH-1:0] cur, input logic [SEVR_WIDTH-1:0] sets,
			input logic [SEVR_WIDTH-1:0] clrs, input logic rd, input logic [SEVR_WIDTH-1:0] mask);
		logic [SEVR_WIDTH-1:0] kept;
		kept = rd ? SEVR_RESET_VALUE : cur;
		return ((kept & ~clrs) | sets) & mask;
	endfunction

	logic [1:0] rst_sync;
	logic rst_n_int;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n_int = rst_sync[1];

	logic [SEVR_WIDTH-1:0] measurement_event_reg, next_measurement_event_reg;
	logic [SEVR_WIDTH-1:0] questionable_event_reg, next_questionable_event_reg;
	logic [SEVR_WIDTH-1:0] operation_event_reg, next_operation_event_reg;
	logic next_answer_valid;
	sevr_answer_t next_answer;
	logic take;
	logic [SEVR_WIDTH-1:0] meas_set, ques_set, ques_clr, oper_set, oper_clr;

	assign query_ready = 1'b1; // single-cycle read, never stalls
	assign take = ce && query_valid && query_sel != SEVR_SEL_NONE;

	always_comb begin
		meas_set = SEVR_RESET_VALUE;
		meas_set[SEVR_MEAS_OVERFLOW_POS] = cond.reading_overflow;
		meas_set[SEVR_MEAS_TIMEOUT_POS] = cond.pulse_timeout;
		meas_set[SEVR_MEAS_READY_POS] = cond.reading_ready;
		meas_set[SEVR_MEAS_AVERAGE_POS] = cond.average_done;
		ques_set = SEVR_RESET_VALUE;
		ques_set[SEVR_QUES_CAL_POS] = cond.cal_invalid;
		ques_clr = SEVR_RESET_VALUE;
		ques_clr[SEVR_QUES_CAL_POS] = cond.cal_done_ok;
		oper_set = SEVR_RESET_VALUE;
		oper_set[SEVR_OPER_LIMIT_POS] = cond.in_limit;
		oper_set[SEVR_OPER_TRIP_POS] = cond.limit_tripped;
		oper_set[SEVR_OPER_THERMAL_POS] = cond.thermal_off;
		oper_set[SEVR_OPER_SUPPLY_POS] = cond.supply_off | cond.thermal_off;
		oper_clr = SEVR_RESET_VALUE;
		oper_clr[SEVR_OPER_LIMIT_POS] = ~cond.in_limit;
		oper_clr[SEVR_OPER_TRIP_POS] = cond.output_on;
		oper_clr[SEVR_OPER_THERMAL_POS] = cond.output_on;
	end

	always_comb begin
		next_measurement_event_reg = update(measurement_event_reg, meas_set, SEVR_RESET_VALUE,
			take && query_sel == SEVR_SEL_MEAS, SEVR_MEAS_MASK);
		next_questionable_event_reg = update(questionable_event_reg, ques_set, ques_clr,
			take && query_sel == SEVR_SEL_QUES, SEVR_QUES_MASK);
		next_operation_event_reg = update(operation_event_reg, oper_set, oper_clr,
			take && query_sel == SEVR_SEL_OPER, SEVR_OPER_MASK);
		next_answer_valid = take;
		next_answer = answer;
		if (take) begin
			case (query_sel)
				SEVR_SEL_MEAS: next_answer.raw = measurement_event_reg;
				SEVR_SEL_QUES: next_answer.raw = questionable_event_reg;
				SEVR_SEL_OPER: next_answer.raw = operation_event_reg;
				default: next_answer.raw = SEVR_RESET_VALUE;
			endcase
			next_answer.digits = to_decimal(next_answer.raw);
		end
	end

	// value returned is the pre-clear content
	always_ff @(posedge mclk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			measurement_event_reg <= SEVR_RESET_VALUE;
			questionable_event_reg <= SEVR_RESET_VALUE;
			operation_event_reg <= SEVR_RESET_VALUE;
			answer_valid <= 1'b0;
			answer <= '0;
		end else if (ce) begin
			measurement_event_reg <= next_measurement_event_reg;
			questionable_event_reg <= next_questionable_event_reg;
			operation_event_reg <= next_operation_event_reg;
			answer_valid <= next_answer_valid;
			answer <= next_answer;
		end
	end

	assign meas_now = measurement_event_reg;
	assign ques_now = questionable_event_reg;
	assign oper_now = operation_event_reg;

endmodule
`default_nettype wire

// *** verification/sevr_status_event_registers_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module sevr_status_event_registers_asserts
	import sevr_pkg::*;
(
	input wire logic mclk, // clock
	input wire logic rstn, // reset
	input wire logic ce, // enable
	input wire sevr_cond_t cond, // events
	input wire logic query_valid, // request
	input wire sevr_sel_t query_sel, // select
	input wire logic answer_valid, // strobe
	input wire sevr_answer_t answer, // answer
	input wire logic [SEVR_WIDTH-1:0] meas_now, // meas
	input wire logic [SEVR_WIDTH-1:0] ques_now, // ques
	input wire logic [SEVR_WIDTH-1:0] oper_now // oper
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence s_rd; ce && query_valid && query_sel == SEVR_SEL_MEAS; endsequence
	sequence s_ans; answer_valid && answer.raw == $past(meas_now); endsequence
	property p_ans; s_rd |=> s_ans; endproperty
	a_ans: assert property (p_ans) else $error("bad answer");
	property p_clr; s_rd ##0 cond == '0 |=> meas_now == '0; endproperty
	a_clr: assert property (p_clr) else $error("no clear");
	property p_ovf; ce && cond.reading_overflow |=> meas_now[3]; endproperty
	a_ovf: assert property (p_ovf) else $error("no overflow");
	property p_cal; ce && cond.cal_invalid |=> ques_now[8]; endproperty
	a_cal: assert property (p_cal) else $error("no cal");
	property p_lim; ce && cond.in_limit |=> oper_now[3]; endproperty
	a_lim: assert property (p_lim) else $error("no limit");
	property p_unl; ce && !cond.in_limit |=> !oper_now[3]; endproperty
	a_unl: assert property (p_unl) else $error("limit stuck");
	property p_on; ce && cond.output_on && cond[3:2] == '0 |=> oper_now[5:4] == '0; endproperty
	a_on: assert property (p_on) else $error("trip stuck");
	property p_ref; !(ce && query_valid && query_sel != SEVR_SEL_NONE) |=> !answer_valid; endproperty
	a_ref: assert property (p_ref) else $error("stray answer");
endmodule
bind sevr_status_event_registers sevr_status_event_registers_asserts u_chk(.mclk(mclk), .rstn(rstn), .ce(ce),
	.cond(cond), .query_valid(query_valid), .query_sel(query_sel), .answer_valid(answer_valid), .answer(answer),
	.meas_now(meas_now), .ques_now(ques_now), .oper_now(oper_now));
`default_nettype wire

// *** verification/sevr_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module sevr_host
	import sevr_pkg::*;
(
	input wire sevr_answer_t answer, // last answer
	output logic [16:0] value // reply as integer
);
	always_comb begin
		value = '0;
		for (int i = SEVR_DEC_DIGITS - 1; i >= 0; i--) value = 17'(value * 10 + answer.digits[i*4+:4]);
	end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
	import sevr_pkg::*;
	logic mclk = 0, rstn = 0, query_valid = 0, answer_valid, ce = 1, query_ready;
	sevr_sel_t query_sel = SEVR_SEL_NONE;
	sevr_cond_t cond = '0;
	sevr_answer_t answer;
	logic [15:0] meas_now, ques_now, oper_now;
	logic [16:0] value;
	int fails = 0, n_tests = 0;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin $display("MISMATCH %0t %h %h", $time, a, b); fails++; end end
	always #2 mclk = ~mclk;
	sevr_status_event_registers u_dut(.mclk(mclk), .rstn(rstn), .ce(ce), .cond(cond), .query_valid(query_valid),
		.query_sel(query_sel), .query_ready(query_ready), .answer_valid(answer_valid), .answer(answer), .meas_now(meas_now),
		.ques_now(ques_now), .oper_now(oper_now));
	sevr_host u_host(.answer(answer), .value(value));
	task automatic ev(input sevr_cond_t c);
		@(posedge mclk) cond <= c;
		@(posedge mclk) cond <= '0;
		#1;
	endtask
	task automatic rd(input sevr_sel_t s, input sevr_cond_t c, input logic [15:0] e);
		@(posedge mclk) begin query_valid <= 1'b1; query_sel <= s; cond <= c; end
		@(posedge mclk) begin query_valid <= 1'b0; cond <= '0; end
		#1 `CHK(answer_valid, s != SEVR_SEL_NONE)
		if (s != SEVR_SEL_NONE) begin `CHK(answer.raw, e) `CHK(value, {1'b0, e}) end
	endtask
	task automatic finish_test;
		$display("compares %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		repeat (4) @(posedge mclk);
		#1 `CHK({meas_now, ques_now, oper_now}, {3{SEVR_RESET_VALUE}})
		`CHK(query_ready, 1'b1)
		ev(11'h500); // overflow and ready
		rd(SEVR_SEL_MEAS, '0, 16'h0028);
		`CHK(meas_now, 16'h0000)
		ev(11'h280); // timeout and average
		rd(SEVR_SEL_MEAS, 11'h100, 16'h0210);
		`CHK(meas_now, 16'h0020)
		$display("test meas done");
		ev(11'h7de); // every setting event at once
		`CHK({meas_now, ques_now, oper_now}, {SEVR_MEAS_MASK, SEVR_QUES_MASK, SEVR_OPER_MASK})
		rd(SEVR_SEL_MEAS, '0, 16'h0238);
		ev(11'h020); // calibration passed
		`CHK(ques_now, 16'h0000)
		ev(11'h001); // output back on
		`CHK(oper_now, 16'h0040)
		rd(SEVR_SEL_OPER, '0, 16'h0040);
		rd(SEVR_SEL_QUES, 11'h040, 16'h0000);
		`CHK(ques_now, 16'h0100)
		rd(SEVR_SEL_NONE, '0, 16'h0000); // refused select keeps contents
		`CHK(ques_now, 16'h0100)
		$display("test mixed done");
		@(posedge mclk) cond <= 11'h010; // current limit held
		repeat (3) @(posedge mclk);
		#1 `CHK(oper_now[3], 1'b1)
		ev(11'h000);
		`CHK(oper_now[3], 1'b0)
		$display("test limit done");
		ev(11'h002); // supply shutdown alone
		`CHK(oper_now, 16'h0040)
		@(posedge mclk) begin ce <= 1'b0; query_valid <= 1'b1; query_sel <= SEVR_SEL_OPER; cond <= 11'h400; end
		@(posedge mclk) begin ce <= 1'b1; query_valid <= 1'b0; cond <= '0; end
		#1 `CHK({answer_valid, meas_now, oper_now}, {1'b0, 16'h0000, 16'h0040}) // disabled edge changes nothing
		rd(SEVR_SEL_OPER, '0, 16'h0040);
		`CHK(oper_now, 16'h0000)
		$display("test enable done");
		finish_test;
	end
endmodule
`default_nettype wire
